// *** pkg/drc_pkg.sv ***
// constants, types and decode helpers of the reference converter control block
package drc_pkg;
    // byte address width of the register window
    localparam int ADDR_W = 4;
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] LEVEL_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
    // control field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_LPS_BIT = 6;
    localparam int CTRL_OE_BIT = 5;
    localparam int CTRL_PSS_LSB = 2;
    localparam int CTRL_NSS_BIT = 0;
    // writable bits of the control and level registers, the rest read zero
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hed;
    localparam logic [7:0] LEVEL_WRITE_MASK = 8'h1f;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    // status field positions
    localparam int STAT_TOP_BIT = 0;
    localparam int STAT_BOTTOM_BIT = 1;
    localparam int STAT_PIN_BIT = 2;
    localparam int STAT_ACTIVE_BIT = 3;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // positive source choices
    typedef enum logic [1:0] {
        PSS_SUPPLY = 2'h0,
        PSS_EXT_PIN = 2'h1,
        PSS_FIXED_REF = 2'h2,
        PSS_RESERVED = 2'h3
    } drc_pos_src_t;

    // register selected by an address
    typedef enum logic [1:0] {
        SEL_CTRL = 2'h0,
        SEL_LEVEL = 2'h1,
        SEL_STATUS = 2'h3,
        SEL_NONE = 2'h2
    } drc_reg_sel_t;

    // shared by the write and the read path
    function automatic drc_reg_sel_t drc_decode(input logic [ADDR_W-1:0] addr);
        drc_reg_sel_t sel;
        sel = SEL_NONE;
        if (addr == CTRL_OFFSET) begin
            sel = SEL_CTRL;
        end else if (addr == LEVEL_OFFSET) begin
            sel = SEL_LEVEL;
        end else if (addr == STATUS_OFFSET) begin
            sel = SEL_STATUS;
        end
        return sel;
    endfunction

    // one-hot top source from the select field, reserved gives none
    function automatic logic [2:0] drc_top_onehot(input logic [1:0] pss);
        logic [2:0] oh;
        oh = 3'h0;
        case (drc_pos_src_t'(pss))
            PSS_SUPPLY: oh = 3'h1;
            PSS_EXT_PIN: oh = 3'h2;
            PSS_FIXED_REF: oh = 3'h4;
            default: oh = 3'h0;
        endcase
        return oh;
    endfunction
endpackage

// *** pkg/drc_ladder_if.sv ***
// register write strobes and ladder selection between bus side and ladder control
`timescale 1ns/100ps
interface drc_ladder_if #(parameter int LEVEL_W = 5);
    logic wr_ctrl; // one-cycle control write strobe
    logic wr_level; // one-cycle level write strobe
    logic [7:0] wdata; // byte written
    logic [7:0] ctrl_q; // control register
    logic [7:0] level_q; // level register, upper bits zero
    logic [LEVEL_W-1:0] tap; // ladder tap code
    logic active; // converter running
    logic top_connect; // top end of ladder tied to its source
    logic bottom_connect; // bottom end tied to its source
    logic [2:0] top_src; // one-hot supply, pin, fixed reference
    logic bottom_src_ext; // bottom from external pin instead of ground
    logic pin_route; // voltage routed to the output pin
    modport regs(output wr_ctrl, wr_level, wdata, input ctrl_q, level_q, tap, active,
        top_connect, bottom_connect, top_src, bottom_src_ext, pin_route);
    modport ladder(input wr_ctrl, wr_level, wdata, output ctrl_q, level_q, tap, active,
        top_connect, bottom_connect, top_src, bottom_src_ext, pin_route);
endinterface

// *** design/drc_ladder.sv ***
// control and level registers with ladder tap and source selection
`timescale 1ns/100ps
module drc_ladder #(
    parameter int LEVEL_W = 5
) (
    input wire logic core_clk,
    input wire logic resetn,
    drc_ladder_if.ladder lif
);
    // the level must fit the byte-wide register
    if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_width
        $error("drc_ladder: LEVEL_W must be 1 to 8");
    end

    // written values, unimplemented bits stripped
    wire logic [7:0] wr_ctrl_val = lif.wdata & drc_pkg::CTRL_WRITE_MASK;
    wire logic [7:0] wr_level_val = lif.wdata & drc_pkg::LEVEL_WRITE_MASK;
    // reset forces the documented values; only bus writes change them otherwise
    wire logic [7:0] next_ctrl = !resetn ? drc_pkg::CTRL_RESET :
        (lif.wr_ctrl ? wr_ctrl_val : lif.ctrl_q);
    wire logic [7:0] next_level = !resetn ? drc_pkg::LEVEL_RESET :
        (lif.wr_level ? wr_level_val : lif.level_q);
    // fields of the next control value
    wire logic next_en = next_ctrl[drc_pkg::CTRL_EN_BIT];
    wire logic next_lps = next_ctrl[drc_pkg::CTRL_LPS_BIT];
    wire logic [1:0] next_pss = next_ctrl[drc_pkg::CTRL_PSS_LSB +: 2];
    // reserved code never names a source
    function automatic logic drc_pos_src_t_ok(input logic [1:0] pss);
        return pss != drc_pkg::PSS_RESERVED;
    endfunction

    // reserved select leaves the top end floating rather than guessing a source
    wire logic next_pss_ok = drc_pos_src_t_ok(next_pss);
    // low-power: when stopped one end stays tied, the top with low-power set, else the bottom; none with low-power and the reserved select
    wire logic next_top = next_pss_ok && (next_en || next_lps);
    wire logic next_bottom = next_en || !next_lps;

    // selection taken from the next value so it moves on the write's own edge
    always_ff @(posedge core_clk) begin
        lif.ctrl_q <= next_ctrl;
        lif.level_q <= next_level;
        lif.tap <= next_level[LEVEL_W-1:0];
        lif.active <= next_en;
        lif.top_connect <= next_top;
        lif.bottom_connect <= next_bottom;
        lif.top_src <= drc_pkg::drc_top_onehot(next_pss);
        lif.bottom_src_ext <= next_ctrl[drc_pkg::CTRL_NSS_BIT];
        lif.pin_route <= next_ctrl[drc_pkg::CTRL_OE_BIT];
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    tap_follows_a: assert property (lif.wr_level |=> lif.tap == $past(lif.wdata[LEVEL_W-1:0]))
        else $error("tap did not follow the level write");
    enable_gates_a: assert property (lif.wr_ctrl |=>
        (lif.active == $past(lif.wdata[drc_pkg::CTRL_EN_BIT])))
        else $error("active does not match the enable written");
    low_power_a: assert property (!lif.active && lif.ctrl_q[1 +: 3] != 3'h6 |->
        lif.bottom_connect != lif.ctrl_q[drc_pkg::CTRL_LPS_BIT])
        else $error("low-power end selection wrong");
    running_ends_a: assert property (lif.active |-> lif.bottom_connect)
        else $error("bottom end dropped while running");
    pos_decode_a: assert property (lif.wr_ctrl && lif.wdata[3:2] == 2'h2 |=>
        lif.top_src == 3'h4 ##1 lif.top_src == 3'h4 || $past(lif.wr_ctrl))
        else $error("fixed reference select decoded wrong");
    unimpl_zero_a: assert property ((lif.ctrl_q & ~drc_pkg::CTRL_WRITE_MASK) == 8'h00 &&
        (lif.level_q & ~drc_pkg::LEVEL_WRITE_MASK) == 8'h00)
        else $error("unimplemented bit read as one");
    // reset itself is the trigger, so the default disable must not apply here
    reset_clear_a: assert property (@(posedge core_clk) disable iff (1'b0) !resetn |=>
        lif.ctrl_q == drc_pkg::CTRL_RESET && lif.tap == '0 && !lif.active && !lif.pin_route)
        else $error("reset left the converter configured");
endmodule // drc_ladder

// *** design/drc_top.sv ***
// reference converter control: bus slave, registers and reference pin takeover
`timescale 1ns/100ps
module drc_top #(
    parameter int LEVEL_W = 5
) (
    input wire logic core_clk,
    input wire logic resetn,
    // write address channel
    input wire logic [drc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [drc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog ladder controls
    output logic [LEVEL_W-1:0] ladder_tap,
    output logic ladder_active,
    output logic ladder_top_connect,
    output logic ladder_bottom_connect,
    output logic [2:0] ladder_top_source,
    output logic ladder_bottom_source_ext,
    output logic reference_output_pin_connect,
    // port logic of the shared output pin
    input wire logic port_data,
    input wire logic port_drive,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pin_input_enable,
    output logic port_read
);
    // one bus beat is a register, so the level must fit a byte
    if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_width
        $error("drc_top: LEVEL_W must be 1 to 8");
    end

    // carrier to the ladder control
    drc_ladder_if #(.LEVEL_W(LEVEL_W)) lif ();

    // registers and selection live next to the ladder decode
    drc_ladder #(
        .LEVEL_W(LEVEL_W)
    ) u_ladder (
        .core_clk(core_clk),
        .resetn(resetn),
        .lif(lif)
    );

    // ladder outputs are flops inside the ladder control
    assign ladder_tap = lif.tap;
    assign ladder_active = lif.active;
    assign ladder_top_connect = lif.top_connect;
    assign ladder_bottom_connect = lif.bottom_connect;
    assign ladder_top_source = lif.top_src;
    assign ladder_bottom_source_ext = lif.bottom_src_ext;
    assign reference_output_pin_connect = lif.pin_route;

    // ---------------- write path ----------------
    logic aw_held; // address taken, waiting for data or response
    logic w_held; // data taken, waiting for address or response
    logic [drc_pkg::ADDR_W-1:0] aw_addr_q; // held write address
    logic [7:0] w_byte_q; // held low byte
    logic w_lane_q; // low byte lane enabled

    // handshakes
    wire logic aw_fire = s_axi_awvalid && s_axi_awready;
    wire logic w_fire = s_axi_wvalid && s_axi_wready;
    wire logic b_fire = s_axi_bvalid && s_axi_bready;
    // commit once both halves are held and no response is pending
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire drc_pkg::drc_reg_sel_t wr_sel = drc_pkg::drc_decode(aw_addr_q);
    // status is read-only: a write there is accepted and dropped
    wire logic wr_mapped = wr_sel != drc_pkg::SEL_NONE;

    // strobes to the register file, byte lane 0 carries the registers
    assign lif.wr_ctrl = do_write && w_lane_q && wr_sel == drc_pkg::SEL_CTRL;
    assign lif.wr_level = do_write && w_lane_q && wr_sel == drc_pkg::SEL_LEVEL;
    assign lif.wdata = w_byte_q;

    // address and data taken in either order, readies drop until the response
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else begin
            // capture address
            if (aw_fire) begin
                s_axi_awready <= 1'b0;
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            // capture data
            if (w_fire) begin
                s_axi_wready <= 1'b0;
                w_held <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            // halves consumed by the commit
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            // reopen only after the response is taken: one write in flight
            if (b_fire) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= drc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? drc_pkg::RESP_OKAY : drc_pkg::RESP_SLVERR;
        end else if (b_fire) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- read path ----------------
    wire logic ar_fire = s_axi_arvalid && s_axi_arready;
    wire logic r_fire = s_axi_rvalid && s_axi_rready;
    wire drc_pkg::drc_reg_sel_t rd_sel = drc_pkg::drc_decode(s_axi_araddr);
    // status shows the ladder state actually applied
    wire logic [7:0] status_val = {4'h0, lif.active, lif.pin_route, lif.bottom_connect,
        lif.top_connect};
    // read mux, unimplemented bits already zero in the registers
    wire logic [7:0] rd_byte = (rd_sel == drc_pkg::SEL_CTRL) ? lif.ctrl_q :
        (rd_sel == drc_pkg::SEL_LEVEL) ? lif.level_q :
        (rd_sel == drc_pkg::SEL_STATUS) ? status_val : 8'h00;

    // one read in flight, data sampled on the address edge
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= drc_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= (rd_sel == drc_pkg::SEL_NONE) ? drc_pkg::RESP_SLVERR :
                drc_pkg::RESP_OKAY;
        end else if (r_fire) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- pin takeover ----------------
    // routed pin: digital driver off, input detector off, port bit reads zero
    wire logic next_pin_oe_n = lif.pin_route || !port_drive;
    wire logic next_pin_out = !lif.pin_route && port_data;
    wire logic next_port_read = !lif.pin_route && pin_in;

    // one cycle behind the control bit; port settings cannot override it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_oe_n <= 1'b1;
            pin_out <= 1'b0;
            pin_input_enable <= 1'b1;
            port_read <= 1'b0;
        end else begin
            pin_oe_n <= next_pin_oe_n;
            pin_out <= next_pin_out;
            pin_input_enable <= !lif.pin_route;
            port_read <= next_port_read;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    pin_release_a: assert property (lif.pin_route |=> pin_oe_n && !pin_input_enable)
        else $error("routed pin still driven or sensed");
    port_zero_a: assert property (lif.pin_route ##1 lif.pin_route |-> port_read == 1'b0)
        else $error("routed pin port bit read nonzero");
    write_response_a: assert property (do_write |=> s_axi_bvalid && !aw_held && !w_held)
        else $error("write committed without a response");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    ctrl_write_a: assert property (lif.wr_ctrl |=>
        lif.ctrl_q == ($past(w_byte_q) & drc_pkg::CTRL_WRITE_MASK))
        else $error("control write not applied next edge");
endmodule // drc_top

// *** test/test_dac_reference_control.sv ***
// self-checking bench for the reference converter control block
`timescale 1ns/100ps
module test_dac_reference_control;
    // one table row: control and level written, ladder flags expected
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] level;
        logic [7:0] flags; // active, top, bottom, source[2:0], bottom ext, pin
    } drc_row_t;

    logic core_clk, resetn;
    logic [drc_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [4:0] ladder_tap;
    logic ladder_active, ladder_top_connect, ladder_bottom_connect, ladder_bottom_source_ext;
    logic [2:0] ladder_top_source;
    logic reference_output_pin_connect;
    logic port_data, port_drive, pin_in, pin_out, pin_oe_n, pin_input_enable, port_read;
    int err_count = 0; // mismatches seen
    int checks_done = 0; // comparisons made
    drc_row_t rows [8];
    logic [31:0] rd; // last read data

    drc_top #(.LEVEL_W(5)) dut (.core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ladder_tap(ladder_tap), .ladder_active(ladder_active),
        .ladder_top_connect(ladder_top_connect), .ladder_bottom_connect(ladder_bottom_connect),
        .ladder_top_source(ladder_top_source),
        .ladder_bottom_source_ext(ladder_bottom_source_ext),
        .reference_output_pin_connect(reference_output_pin_connect),
        .port_data(port_data), .port_drive(port_drive), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_input_enable(pin_input_enable), .port_read(port_read));

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // verdict and end of run, reached from the main sequence or a timeout
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // the one compare task, values widened to a word
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // a wait that used up its bound
    task automatic timed_out();
        err_count++;
        $display("mismatch handshake expected answer seen none");
        results();
    endtask

    // bus write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [3:0] addr, input logic [31:0] data,
        input logic [3:0] strb, input logic [1:0] exp_resp);
        int n;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) timed_out();
        check_val("bresp", 32'(exp_resp), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        // spare edge lets the pin outputs follow and keeps strobes apart
        @(posedge core_clk);
    endtask

    // bus read: data and response taken at the edge that shows rvalid
    task automatic axi_read(input logic [3:0] addr, input logic [1:0] exp_resp);
        int n;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) timed_out();
        rd = s_axi_rdata;
        check_val("rresp", 32'(exp_resp), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // ladder outputs packed like the row flags, tap on top
    function automatic logic [12:0] ladder_vec();
        return {ladder_tap, ladder_active, ladder_top_connect, ladder_bottom_connect,
            ladder_top_source, ladder_bottom_source_ext, reference_output_pin_connect};
    endfunction

    // main sequence
    initial begin
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_bready = 1'b0;
        s_axi_rready = 1'b0;
        port_data = 1'b1;
        port_drive = 1'b1;
        pin_in = 1'b1;
        resetn = 1'b0;
        // enabled sources, clamps, reserved select, unimplemented bits, pin route
        rows = '{'{8'h80, 8'h10, 8'he4}, '{8'h84, 8'h1f, 8'he8}, '{8'h89, 8'h01, 8'hf2},
            '{8'h40, 8'h1f, 8'h44}, '{8'h00, 8'h00, 8'h24}, '{8'h8c, 8'h0a, 8'ha0},
            '{8'hff, 8'hff, 8'ha3}, '{8'h60, 8'h00, 8'h45}};
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        foreach (rows[i]) begin
            axi_write(drc_pkg::CTRL_OFFSET, 32'(rows[i].ctrl), 4'hf, drc_pkg::RESP_OKAY);
            axi_write(drc_pkg::LEVEL_OFFSET, 32'(rows[i].level), 4'h1, drc_pkg::RESP_OKAY);
            check_val("ladder", 32'({rows[i].level[4:0], rows[i].flags}),
                32'(ladder_vec()));
            check_val("pin", rows[i].flags[0] ? 32'h4 : 32'hb,
                32'({pin_out, pin_oe_n, pin_input_enable, port_read}));
            axi_read(drc_pkg::CTRL_OFFSET, drc_pkg::RESP_OKAY);
            check_val("ctrl", 32'(rows[i].ctrl & drc_pkg::CTRL_WRITE_MASK), rd);
            axi_read(drc_pkg::LEVEL_OFFSET, drc_pkg::RESP_OKAY);
            check_val("level", 32'(rows[i].level & drc_pkg::LEVEL_WRITE_MASK), rd);
            axi_read(drc_pkg::STATUS_OFFSET, drc_pkg::RESP_OKAY);
            check_val("status", 32'({rows[i].flags[7], rows[i].flags[0],
                rows[i].flags[5], rows[i].flags[6]}), rd);
        end
        // unmapped place: refused both ways, nothing changes
        axi_write(4'hc, 32'h0000_00ff, 4'hf, drc_pkg::RESP_SLVERR);
        axi_read(4'hc, drc_pkg::RESP_SLVERR);
        check_val("unmapped", 32'h0, rd);
        // read-only status and a write with lane 0 off are both ignored
        axi_write(drc_pkg::STATUS_OFFSET, 32'h0000_00ff, 4'hf, drc_pkg::RESP_OKAY);
        axi_write(drc_pkg::CTRL_OFFSET, 32'h0000_0080, 4'he, drc_pkg::RESP_OKAY);
        axi_read(drc_pkg::CTRL_OFFSET, drc_pkg::RESP_OKAY);
        check_val("ctrl_kept", 32'h60, rd);
        // idle stands in for sleep, entered with the converter already disabled
        repeat (20) @(posedge core_clk);
        axi_read(drc_pkg::CTRL_OFFSET, drc_pkg::RESP_OKAY);
        check_val("ctrl_idle", 32'h60, rd);
        // unrouted pin hands back port values, here all low
        port_data <= 1'b0;
        port_drive <= 1'b0;
        pin_in <= 1'b0;
        axi_write(drc_pkg::CTRL_OFFSET, 32'h0000_00a0, 4'h1, drc_pkg::RESP_OKAY);
        axi_write(drc_pkg::CTRL_OFFSET, 32'h0000_0080, 4'h1, drc_pkg::RESP_OKAY);
        check_val("pin_free", 32'h6,
            32'({pin_out, pin_oe_n, pin_input_enable, port_read}));
        // reset in mid-run with the reference routed and a level set
        axi_write(drc_pkg::CTRL_OFFSET, 32'h0000_00ad, 4'h1, drc_pkg::RESP_OKAY);
        axi_write(drc_pkg::LEVEL_OFFSET, 32'h0000_0015, 4'h1, drc_pkg::RESP_OKAY);
        port_data <= 1'b1;
        port_drive <= 1'b1;
        pin_in <= 1'b1;
        resetn <= 1'b0;
        repeat (6) @(posedge core_clk);
        check_val("ladder_rst", 32'h24, 32'(ladder_vec()));
        resetn <= 1'b1;
        @(posedge core_clk);
        @(posedge core_clk);
        check_val("pin_rst", 32'hb,
            32'({pin_out, pin_oe_n, pin_input_enable, port_read}));
        // bus reopened by reset: awready, wready and arready all high
        check_val("readies", 32'h7, 32'({s_axi_awready, s_axi_wready, s_axi_arready}));
        axi_read(drc_pkg::CTRL_OFFSET, drc_pkg::RESP_OKAY);
        check_val("ctrl_rst", 32'(drc_pkg::CTRL_RESET), rd);
        axi_read(drc_pkg::LEVEL_OFFSET, drc_pkg::RESP_OKAY);
        check_val("level_rst", 32'(drc_pkg::LEVEL_RESET), rd);
        results();
    end
endmodule // test_dac_reference_control
